// *** rtl/bfp_fault_ctrl.sv ***
/*
 Fault detection and response sequencer of a power backup manager.
 Assumes comparator levels arrive asynchronously, completion pulses
 come from logic on i_ref_clk, and registers sit behind a plain port.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
// Notes on behaviour
// [RULE_01] Bus short in normal: buck, flag, alert
// [RULE_02] Early bus short: off, wait eight soft-starts
// [RULE_03] Storage check opens 56ms into pre-charge
// [RULE_04] Storage short: switch open, converter off, flag
// [RULE_05] Storage short latches off, then restarts
// [RULE_06] Fast charge short: below 0.7V or drop
// [RULE_07] Buck mode ignores storage drop check
// [RULE_08] Reverse current trips unless disable bit set
// [RULE_09] Reverse trip: status clear, flag, alert
// [RULE_10] Buck end after reverse restarts power-on
// [RULE_11] Storage over-voltage stops boost, sets flag
// [RULE_12] Boost resumes 1V below over-voltage threshold
// [RULE_13] Above 125C sets warning flag
// [RULE_14] Warning clear honoured only below 100C
// [RULE_15] At 150C sets shutdown flag
// [RULE_16] Mode bit picks instant off or buck
// [RULE_17] Recovery below 125C like supply return
// [RULE_18] Shutdown clear honoured only below 125C
// [RULE_19] At 165C everything turns off
// [RULE_20] Registers load defaults at reset
// [RULE_21] Input over-voltage: flag, bus-good low, buck
// [RULE_22] Fixed event bit assignments
// [RULE_23] Alert holds until all unmasked events cleared
// [RULE_24] Bus-good low on feedback, input faults
// [RULE_25] Power fails cause buck, short drops storage-good
// [RULE_26] Latches sticky; alert ORs unmasked latches
`timescale 1ns/100ps
`default_nettype none
`include "bfp_consts.svh"

module bfp_fault_ctrl #(
   parameter logic [21:0] P_MON_CYC = 22'(`BFP_T_MON_MS * `BFP_CLK_KHZ),
   parameter logic [21:0] P_SS_CYC  = 22'(`BFP_T_SS_MS * `BFP_CLK_KHZ),
   parameter logic [21:0] P_POR_CYC = 22'(`BFP_T_POR_MS * `BFP_CLK_KHZ)
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   input  wire logic [3:0]        i_addr,
   input  wire logic [7:0]        i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [7:0]        o_rdata,
   input  wire bfp_pkg::bfp_cmp_t i_cmp,
   input  wire logic              i_meas_done,
   input  wire logic              i_adc_done,
   output bfp_pkg::bfp_pwr_t      o_pwr,
   output logic      [4:0]        o_storage_overvolt_threshold,
   output logic                   o_alert_pin_oe,
   output logic                   o_bus_good_pin_oe,
   output logic                   o_storage_good_pin_oe
);

   localparam logic [21:0] RETRY_CYC = 22'(P_SS_CYC * `BFP_RETRY_SS);

   bfp_pkg::bfp_cmp_t        cmp_meta;
   bfp_pkg::bfp_cmp_t        c;
   bfp_pkg::bfp_state_t      state;
   bfp_pkg::bfp_state_t      next_state;
   bfp_pkg::bfp_pwr_t        next_pwr;
   logic [21:0]              cnt;
   logic                     ovp_hold;
   logic                     therm_buck;
   logic                     next_therm_buck;
   logic                     next_max_peak;
   logic [7:4]               sys_ctl;
   logic [7:0]               safety_function_control;
   logic [7:0]               limit_setup_register;
   logic [7:0]               mask;
   logic [`BFP_NUM_EV-1:0]   ev_set;
   logic [`BFP_NUM_EV-1:0]   ev_clr;
   logic [`BFP_NUM_EV-1:0]   flags;
   logic                     mon_open;
   logic                     alert;
   logic [7:0]               sys_rd;

   // Comparator levels cross into the clock domain
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         cmp_meta <= '0;
         c        <= '0;
      end else begin
         cmp_meta <= i_cmp;
         c        <= cmp_meta;
      end
   end

   // Control registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         sys_ctl                      <= 4'(`BFP_SYS_RST >> 4); // RULE_20
         safety_function_control      <= `BFP_SF_RST;
         limit_setup_register         <= `BFP_LSP_RST;
         mask                         <= `BFP_MASK_RST;
         o_storage_overvolt_threshold <= `BFP_OVP_RST;
      end else if (i_wr) begin
         unique case (i_addr)
            `BFP_ADDR_SYS:  sys_ctl <= i_wdata[7:4];
            `BFP_ADDR_SF:   safety_function_control <= i_wdata;
            `BFP_ADDR_LSP:  limit_setup_register <= i_wdata;
            `BFP_ADDR_MASK: mask <= i_wdata;
            `BFP_ADDR_OVP:  o_storage_overvolt_threshold <= i_wdata[4:0];
            default: ;
         endcase
      end
   end

   // Write-one clears, thermal flags gated by temperature
   always_comb begin
      ev_clr = '0;
      if (i_wr && i_addr == `BFP_ADDR_FLAG)
         ev_clr[7:0] = i_wdata;
      if (i_wr && i_addr == `BFP_ADDR_SYS)
         ev_clr[`BFP_EV_STROVP:`BFP_EV_INFAIL] = i_wdata[3:1];
      if (!c.t_lt_100)
         ev_clr[`BFP_EV_TWARN] = 1'b0; // RULE_14
      if (c.t_gt_125)
         ev_clr[`BFP_EV_TSD] = 1'b0; // RULE_18
   end

   bfp_event_latch u_latch (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_set     (ev_set),
      .i_clr     (ev_clr),
      .o_q       (flags)
   );

   // Storage over-voltage hysteresis
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b)
         ovp_hold <= 1'b0;
      else if (c.str_over_ovp)
         ovp_hold <= 1'b1; // RULE_11
      else if (c.str_below_ovp_1v)
         ovp_hold <= 1'b0; // RULE_12
   end

   // Phase timer restarts on every state change
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b || next_state != state)
         cnt <= '0;
      else if (cnt != '1)
         cnt <= cnt + 22'h1;
   end

   assign mon_open = cnt >= P_MON_CYC; // RULE_03

   // Sequencer
   always_comb begin
      next_state      = state;
      next_therm_buck = therm_buck;
      next_max_peak   = o_pwr.max_peak;
      ev_set          = '0;
      ev_set[`BFP_EV_TWARN]  = c.t_gt_125; // RULE_13
      ev_set[`BFP_EV_TSD]    = c.t_ge_150; // RULE_15
      ev_set[`BFP_EV_MEAS]   = i_meas_done; // RULE_22
      ev_set[`BFP_EV_ADC]    = i_adc_done;
      ev_set[`BFP_EV_STROVP] = c.str_over_ovp && !ovp_hold; // RULE_11
      unique case (state)
         bfp_pkg::ST_SOFTSTART:
            if (cnt >= P_SS_CYC - 22'h1)
               next_state = bfp_pkg::ST_POR_DLY;
         bfp_pkg::ST_POR_DLY: begin
            if (c.bus_short && c.bus_lt_90_vin) begin
               next_state = bfp_pkg::ST_RETRY_WAIT; // RULE_02
               ev_set[`BFP_EV_BUSFAIL] = 1'b1;
            end else if (cnt >= P_POR_CYC - 22'h1)
               next_state = bfp_pkg::ST_PRECHG;
         end
         bfp_pkg::ST_RETRY_WAIT:
            if (cnt >= RETRY_CYC - 22'h1)
               next_state = bfp_pkg::ST_SOFTSTART; // RULE_02
         bfp_pkg::ST_PRECHG, bfp_pkg::ST_NORMAL: begin
            if (c.vin_ovp && !limit_setup_register[`BFP_LSP_OVPDIS]) begin
               next_state = bfp_pkg::ST_BUCK; // RULE_21
               ev_set[`BFP_EV_VINOVP] = 1'b1;
            end else if (c.vin_ocp) begin
               next_state = bfp_pkg::ST_BUCK;
               ev_set[`BFP_EV_OCP] = 1'b1;
            end else if (c.rev_500ma && !safety_function_control[`BFP_SF_REVDIS]) begin
               next_state = bfp_pkg::ST_BUCK; // RULE_08
               ev_set[`BFP_EV_REV] = 1'b1; // RULE_09
            end else if (c.bus_short || c.fbd_low) begin
               next_state = bfp_pkg::ST_BUCK; // RULE_01
               next_max_peak = c.bus_short;
               ev_set[`BFP_EV_BUSFAIL] = 1'b1;
            end else if (c.vin_below_por) begin
               next_state = bfp_pkg::ST_BUCK; // RULE_25
               ev_set[`BFP_EV_INFAIL] = 1'b1;
            end else if (state == bfp_pkg::ST_PRECHG) begin
               if (mon_open && !c.str_gt_0p7) begin
                  next_state = bfp_pkg::ST_LATCH_OFF; // RULE_03
                  ev_set[`BFP_EV_STRSC] = 1'b1;
               end else if (mon_open)
                  next_state = bfp_pkg::ST_NORMAL;
            end else if (!c.str_gt_0p7 || c.str_lt_bus_drop) begin
               next_state = bfp_pkg::ST_LATCH_OFF; // RULE_06
               ev_set[`BFP_EV_STRSC] = 1'b1; // RULE_04
            end
         end
         bfp_pkg::ST_BUCK:
            // No storage drop check while holding up the bus
            if (c.str_below_buckoff) // RULE_07
               next_state = therm_buck ? bfp_pkg::ST_THERM_OFF
                                       : bfp_pkg::ST_SOFTSTART; // RULE_10
         bfp_pkg::ST_LATCH_OFF:
            if (cnt >= P_POR_CYC - 22'h1)
               next_state = bfp_pkg::ST_SOFTSTART; // RULE_05
         bfp_pkg::ST_THERM_OFF, bfp_pkg::ST_HARD_OFF:
            if (!c.t_gt_125)
               next_state = bfp_pkg::ST_SOFTSTART; // RULE_17
      endcase
      if (c.t_ge_150 && !therm_buck && state != bfp_pkg::ST_THERM_OFF
          && state != bfp_pkg::ST_HARD_OFF) begin
         if (sys_ctl[`BFP_SYS_THMODE])
            next_state = bfp_pkg::ST_THERM_OFF; // RULE_16
         else begin
            next_state      = bfp_pkg::ST_BUCK; // RULE_16
            next_therm_buck = 1'b1;
         end
      end
      if (c.t_ge_165)
         next_state = bfp_pkg::ST_HARD_OFF; // RULE_19
      if (next_state != bfp_pkg::ST_BUCK) begin
         next_therm_buck = 1'b0;
         next_max_peak   = 1'b0;
      end
   end

   // Power stage outputs follow the next state
   always_comb begin
      next_pwr.blk_on   = next_state == bfp_pkg::ST_SOFTSTART ||
                          next_state == bfp_pkg::ST_POR_DLY ||
                          next_state == bfp_pkg::ST_PRECHG ||
                          next_state == bfp_pkg::ST_NORMAL; // RULE_25
      next_pwr.str_on   = next_state == bfp_pkg::ST_PRECHG ||
                          next_state == bfp_pkg::ST_NORMAL ||
                          next_state == bfp_pkg::ST_BUCK; // RULE_04
      next_pwr.max_peak = next_max_peak; // RULE_01
      if (next_state == bfp_pkg::ST_BUCK)
         next_pwr.mode = bfp_pkg::MODE_BUCK;
      else if ((next_state == bfp_pkg::ST_PRECHG || next_state == bfp_pkg::ST_NORMAL)
               && !ovp_hold && !c.str_over_ovp)
         next_pwr.mode = bfp_pkg::MODE_BOOST; // RULE_12
      else
         next_pwr.mode = bfp_pkg::MODE_OFF;
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         state      <= bfp_pkg::ST_SOFTSTART;
         therm_buck <= 1'b0;
         o_pwr      <= '0;
      end else begin
         state      <= next_state;
         therm_buck <= next_therm_buck;
         o_pwr      <= next_pwr;
      end
   end

   // Open-drain pins: enable high pulls the pin low
   assign alert = |(flags[7:0] & ~mask) | |flags[`BFP_EV_STROVP:`BFP_EV_INFAIL];

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_alert_pin_oe        <= 1'b1;
         o_bus_good_pin_oe     <= 1'b1;
         o_storage_good_pin_oe <= 1'b1;
      end else begin
         o_alert_pin_oe        <= !alert; // RULE_23
         o_bus_good_pin_oe     <= c.fbd_low || c.vin_below_por || next_state ==
                                  bfp_pkg::ST_BUCK || (c.vin_ovp &&
                                  !limit_setup_register[`BFP_LSP_OVPDIS]); // RULE_24
         o_storage_good_pin_oe <= c.fbs_low ||
                                  next_state == bfp_pkg::ST_LATCH_OFF; // RULE_25
      end
   end

   // Read data stands one cycle after the strobe
   always_comb begin
      sys_rd = {sys_ctl, flags[`BFP_EV_STROVP:`BFP_EV_INFAIL], 1'b0};
      sys_rd[`BFP_SYS_BLK] = o_pwr.blk_on; // RULE_09
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b || !i_rd)
         o_rdata <= 8'h00;
      else begin
         unique case (i_addr)
            `BFP_ADDR_SYS:  o_rdata <= sys_rd;
            `BFP_ADDR_SF:   o_rdata <= safety_function_control;
            `BFP_ADDR_LSP:  o_rdata <= limit_setup_register;
            `BFP_ADDR_FLAG: o_rdata <= flags[7:0];
            `BFP_ADDR_MASK: o_rdata <= mask;
            `BFP_ADDR_OVP:  o_rdata <= {3'h0, o_storage_overvolt_threshold};
            default:        o_rdata <= 8'h00;
         endcase
      end
   end

   property p_bus_short_buck;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state == bfp_pkg::ST_NORMAL && next_state == bfp_pkg::ST_BUCK && c.bus_short)
      |=> o_pwr.mode == bfp_pkg::MODE_BUCK && !o_pwr.blk_on && o_pwr.max_peak
          && flags[`BFP_EV_BUSFAIL] ##1 !o_alert_pin_oe;
   endproperty
   a_bus_short_buck: assert property (p_bus_short_buck) // RULE_01
      else $error("bus short did not force buck with flag and alert");

   property p_retry_off;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(state == bfp_pkg::ST_RETRY_WAIT) |-> !o_pwr.blk_on ##1 !o_pwr.blk_on;
   endproperty
   a_retry_off: assert property (p_retry_off) // RULE_02
      else $error("block switch on during retry wait");

   property p_no_early_short;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (state == bfp_pkg::ST_PRECHG && cnt < P_MON_CYC && !c.t_ge_150)
      |=> state != bfp_pkg::ST_LATCH_OFF;
   endproperty
   a_no_early_short: assert property (p_no_early_short) // RULE_03
      else $error("storage short declared before monitor window");

   property p_latch_off;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(state == bfp_pkg::ST_LATCH_OFF) |-> !o_pwr.str_on
          && o_pwr.mode == bfp_pkg::MODE_OFF && flags[`BFP_EV_STRSC];
   endproperty
   a_latch_off: assert property (p_latch_off) // RULE_04
      else $error("storage short response incomplete");

   property p_buck_no_short;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      state == bfp_pkg::ST_BUCK |=> state != bfp_pkg::ST_LATCH_OFF;
   endproperty
   a_buck_no_short: assert property (p_buck_no_short) // RULE_07
      else $error("storage short declared in buck mode");

   property p_rev_disabled;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      safety_function_control[`BFP_SF_REVDIS] |-> !ev_set[`BFP_EV_REV];
   endproperty
   a_rev_disabled: assert property (p_rev_disabled) // RULE_08
      else $error("reverse trip while protection disabled");

   property p_ovp_stop;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      ovp_hold |=> o_pwr.mode != bfp_pkg::MODE_BOOST;
   endproperty
   a_ovp_stop: assert property (p_ovp_stop) // RULE_11
      else $error("boost running during storage over-voltage");

   property p_warn_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (flags[`BFP_EV_TWARN] && !c.t_lt_100) |=> flags[`BFP_EV_TWARN];
   endproperty
   a_warn_clear: assert property (p_warn_clear) // RULE_14
      else $error("warning cleared while still hot");

   property p_hard_off;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      c.t_ge_165 |=> state == bfp_pkg::ST_HARD_OFF && !o_pwr.blk_on
          && !o_pwr.str_on && o_pwr.mode == bfp_pkg::MODE_OFF;
   endproperty
   a_hard_off: assert property (p_hard_off) // RULE_19
      else $error("circuits not off at extreme temperature");

   property p_alert_hold;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (|(flags[7:0] & ~mask)) |=> !o_alert_pin_oe;
   endproperty
   a_alert_hold: assert property (p_alert_hold) // RULE_23
      else $error("alert released with unmasked event pending");

endmodule

`default_nettype wire

// *** rtl/bfp_consts.svh ***
/*
 Constants of the backup fault protection block: register offsets,
 bit positions, reset values and timing figures.
 Assumes inclusion by the design modules and by the testbench.
*/
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH

`define BFP_ADDR_SYS       4'h0
`define BFP_ADDR_SF        4'h1
`define BFP_ADDR_LSP       4'h2
`define BFP_ADDR_FLAG      4'h3
`define BFP_ADDR_MASK      4'h4
`define BFP_ADDR_OVP       4'h5

`define BFP_SYS_BLK        0
`define BFP_SYS_THMODE     4
`define BFP_SF_REVDIS      6
`define BFP_LSP_OVPDIS     7

`define BFP_EV_TSD         0
`define BFP_EV_TWARN       1
`define BFP_EV_ADC         2
`define BFP_EV_MEAS        3
`define BFP_EV_REV         4
`define BFP_EV_STRSC       5
`define BFP_EV_OCP         6
`define BFP_EV_VINOVP      7
`define BFP_EV_INFAIL      8
`define BFP_EV_BUSFAIL     9
`define BFP_EV_STROVP      10
`define BFP_NUM_EV         11

`define BFP_SYS_RST        8'h00
`define BFP_SF_RST         8'h00
`define BFP_LSP_RST        8'h00
`define BFP_MASK_RST       8'h00
`define BFP_OVP_RST        5'h10

`define BFP_CLK_KHZ        40000
`define BFP_T_MON_MS       56
`define BFP_T_SS_MS        1
`define BFP_T_POR_MS       1
`define BFP_RETRY_SS       8

`endif

// *** rtl/bfp_pkg.sv ***
/*
 Types of the backup fault protection block.
 Assumes bfp_consts.svh is on the include path.
*/
package bfp_pkg;

   typedef enum logic [3:0] {
      ST_SOFTSTART, ST_POR_DLY, ST_RETRY_WAIT, ST_PRECHG, ST_NORMAL,
      ST_BUCK, ST_LATCH_OFF, ST_THERM_OFF, ST_HARD_OFF
   } bfp_state_t;

   typedef enum logic [1:0] {
      MODE_OFF, MODE_BOOST, MODE_BUCK
   } bfp_mode_t;

   typedef struct packed {
      logic bus_short;
      logic bus_lt_90_vin;
      logic str_gt_0p7;
      logic str_lt_bus_drop;
      logic rev_500ma;
      logic str_over_ovp;
      logic str_below_ovp_1v;
      logic t_gt_125;
      logic t_lt_100;
      logic t_ge_150;
      logic t_ge_165;
      logic fbd_low;
      logic vin_below_por;
      logic vin_ovp;
      logic vin_ocp;
      logic str_below_buckoff;
      logic fbs_low;
   } bfp_cmp_t;

   typedef struct packed {
      logic      blk_on;
      logic      str_on;
      bfp_mode_t mode;
      logic      max_peak;
   } bfp_pwr_t;

endpackage

// *** rtl/bfp_event_latch.sv ***
/*
 Sticky event latches, one per event bit, set by hardware and
 cleared by a write of one. Assumes set and clear on the block clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bfp_consts.svh"

module bfp_event_latch (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_rst_b,
   input  wire logic [`BFP_NUM_EV-1:0]  i_set,
   input  wire logic [`BFP_NUM_EV-1:0]  i_clr,
   output logic      [`BFP_NUM_EV-1:0]  o_q
);

   genvar g;
   generate
      for (g = 0; g < `BFP_NUM_EV; g++) begin : g_bit
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b)
               o_q[g] <= 1'b0;
            else if (i_set[g])
               o_q[g] <= 1'b1; // RULE_26
            else if (i_clr[g])
               o_q[g] <= 1'b0;
         end
      end
   endgenerate

endmodule

`default_nettype wire

// *** tb/bfp_host_model.sv ***
/*
 Host-side model of the plain register port: one-cycle write and
 read strobes. Assumes read data stand in the cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module bfp_host_model (
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [3:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd
);
   initial begin
      o_addr = 4'h0;
      o_wdata = 8'h00;
      o_wr = 1'h0;
      o_rd = 1'h0;
   end

   // Ones written to flag bits ask for a clear
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'h1;
      @(posedge i_ref_clk);
      o_wr <= 1'h0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge i_ref_clk);
      o_addr <= a;
      o_rd <= 1'h1;
      @(posedge i_ref_clk);
      o_rd <= 1'h0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/bfp_fault_ctrl_tb.sv ***
/*
 Testbench of the fault block: drives comparators and events, checks
 power outputs, pins and registers. Assumes shortened timing counts.
*/
`timescale 1ns/100ps
`default_nettype none
`include "bfp_consts.svh"
module bfp_fault_ctrl_tb;
   localparam logic [3:0] AS = `BFP_ADDR_SYS;
   localparam logic [3:0] AF = `BFP_ADDR_FLAG;
   localparam logic [1:0] MO = bfp_pkg::MODE_OFF;
   localparam logic [1:0] MS = bfp_pkg::MODE_BOOST;
   localparam logic [1:0] MB = bfp_pkg::MODE_BUCK;
   logic              ref_clk = 1'h0;
   logic              rst_b = 1'h0;
   logic [3:0]        addr;
   logic [7:0]        wdata, rdata;
   logic              wr, rd, alert_oe, busg_oe, strg_oe;
   logic              meas = 1'h0;
   logic              adc = 1'h0;
   logic [4:0]        thr;
   bfp_pkg::bfp_cmp_t cmp, ok, c;
   bfp_pkg::bfp_pwr_t pwr;
   int                n_errors = 0;
   int                tests_run = 0;
   int                cycles = 0;

   always #12.5 ref_clk = ~ref_clk;

   bfp_host_model host (
      .i_ref_clk (ref_clk),
      .i_rdata   (rdata),
      .o_addr    (addr),
      .o_wdata   (wdata),
      .o_wr      (wr),
      .o_rd      (rd)
   );

   bfp_fault_ctrl #(
      .P_MON_CYC (22'h28),
      .P_SS_CYC  (22'ha),
      .P_POR_CYC (22'ha)
   ) dut (
      .i_ref_clk                    (ref_clk),
      .i_rst_b                      (rst_b),
      .i_addr                       (addr),
      .i_wdata                      (wdata),
      .i_wr                         (wr),
      .i_rd                         (rd),
      .o_rdata                      (rdata),
      .i_cmp                        (cmp),
      .i_meas_done                  (meas),
      .i_adc_done                   (adc),
      .o_pwr                        (pwr),
      .o_storage_overvolt_threshold (thr),
      .o_alert_pin_oe               (alert_oe),
      .o_bus_good_pin_oe            (busg_oe),
      .o_storage_good_pin_oe        (strg_oe)
   );

   task automatic end_of_test();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   function automatic logic [7:0] b(input logic x);
      return {7'h0, x};
   endfunction

   task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk(d, exp);
   endtask

   task automatic pchk(input logic s, input logic [1:0] m);
      chk({5'h0, pwr.str_on, pwr.mode}, {5'h0, s, m});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic apply(input bfp_pkg::bfp_cmp_t v);
      cmp <= v;
      cyc(6);
   endtask

   task automatic restart(input bfp_pkg::bfp_cmp_t v, input int n);
      rst_b <= 1'h0;
      cmp <= v;
      cyc(5);
      rst_b <= 1'h1;
      cyc(n);
   endtask

   // Cuts a hang short
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   initial begin
      ok = '0;
      ok.str_gt_0p7 = 1'h1;
      ok.t_lt_100 = 1'h1;
      ok.str_below_ovp_1v = 1'h1;
      cmp = ok;
      // Defaults, unmapped place, rewrite
      restart(ok, 2);
      for (int a = 1; a < 5; a++) rchk(4'(a), 8'h00);
      rchk(`BFP_ADDR_OVP, 8'h10);
      rchk(4'hf, 8'h00);
      chk(b(alert_oe), 8'h01);
      host.wr(`BFP_ADDR_OVP, 8'h0a);
      cyc(1);
      chk({3'h0, thr}, 8'h0a);
      // Early bus short, retry after eight soft-starts
      restart(ok, 12);
      c = ok;
      c.bus_short = 1'h1;
      c.bus_lt_90_vin = 1'h1;
      apply(c);
      chk(b(pwr.blk_on), 8'h00);
      rchk(AS, 8'h04);
      chk(b(alert_oe), 8'h00);
      cmp <= ok;
      cyc(60);
      chk(b(pwr.blk_on), 8'h00);
      cyc(30);
      chk(b(pwr.blk_on), 8'h01);
      // Pre-charge storage short only after the monitor delay
      c = ok;
      c.str_gt_0p7 = 1'h0;
      restart(c, 35);
      rchk(AF, 8'h00);
      cyc(40);
      rchk(AF, 8'h20);
      // Fast-charge short, both causes
      for (int k = 0; k < 2; k++) begin
         restart(ok, 75);
         c = ok;
         c.str_gt_0p7 = k[0];
         c.str_lt_bus_drop = k[0];
         apply(c);
         pchk(1'h0, MO);
         chk(b(strg_oe), 8'h01);
         chk(b(alert_oe), 8'h00);
         rchk(AF, 8'h20);
         cmp <= ok;
         cyc(15);
         chk(b(pwr.blk_on), 8'h01);
      end
      // Bus short in normal; drop check ignored in buck
      restart(ok, 75);
      c = ok;
      c.bus_short = 1'h1;
      c.str_lt_bus_drop = 1'h1;
      apply(c);
      chk(b(pwr.blk_on), 8'h00);
      pchk(1'h1, MB);
      chk(b(pwr.max_peak), 8'h01);
      chk(b(busg_oe), 8'h01);
      chk(b(alert_oe), 8'h00);
      rchk(AS, 8'h04);
      rchk(AF, 8'h00);
      c = ok;
      c.str_below_buckoff = 1'h1;
      apply(c);
      host.wr(AS, 8'h04);
      cyc(2);
      chk(b(alert_oe), 8'h01);
      // Reverse current and input over-voltage, disabled then enabled
      for (int k = 0; k < 2; k++) begin
         restart(ok, 75);
         host.wr(k ? `BFP_ADDR_LSP : `BFP_ADDR_SF, k ? 8'h80 : 8'h40);
         c = ok;
         c.vin_ovp = k[0];
         c.rev_500ma = !k[0];
         apply(c);
         chk(b(pwr.blk_on), 8'h01);
         rchk(AF, 8'h00);
         host.wr(k ? `BFP_ADDR_LSP : `BFP_ADDR_SF, 8'h00);
         cyc(6);
         chk(b(pwr.blk_on), 8'h00);
         pchk(1'h1, MB);
         chk(b(busg_oe), 8'h01);
         chk(b(alert_oe), 8'h00);
         rchk(AF, k ? 8'h80 : 8'h10);
         if (k == 0) rchk(AS, 8'h00);
         c = ok;
         c.str_below_buckoff = 1'h1;
         apply(c);
         chk(b(pwr.blk_on), 8'h01);
      end
      // Input power fail
      restart(ok, 75);
      c = ok;
      c.vin_below_por = 1'h1;
      apply(c);
      chk(b(pwr.blk_on), 8'h00);
      pchk(1'h1, MB);
      chk(b(busg_oe), 8'h01);
      rchk(AS, 8'h02);
      // Storage over-voltage with hysteresis
      restart(ok, 75);
      c = ok;
      c.str_over_ovp = 1'h1;
      c.str_below_ovp_1v = 1'h0;
      apply(c);
      pchk(1'h1, MO);
      rchk(AS, 8'h09);
      chk(b(alert_oe), 8'h00);
      c.str_over_ovp = 1'h0;
      apply(c);
      pchk(1'h1, MO);
      apply(ok);
      pchk(1'h1, MS);
      // Thermal warning, mask, clear levels, stacked events
      restart(ok, 75);
      host.wr(`BFP_ADDR_MASK, 8'h02);
      c = ok;
      c.t_gt_125 = 1'h1;
      c.t_lt_100 = 1'h0;
      apply(c);
      chk(b(alert_oe), 8'h01);
      rchk(AF, 8'h02);
      host.wr(`BFP_ADDR_MASK, 8'h00);
      cyc(2);
      chk(b(alert_oe), 8'h00);
      c.t_gt_125 = 1'h0;
      apply(c);
      host.wr(AF, 8'h02);
      rchk(AF, 8'h02);
      apply(ok);
      meas <= 1'h1;
      adc <= 1'h1;
      cyc(1);
      meas <= 1'h0;
      adc <= 1'h0;
      host.wr(AF, 8'h02);
      rchk(AF, 8'h0c);
      pchk(1'h1, MS);
      host.wr(AF, 8'h08);
      cyc(2);
      chk(b(alert_oe), 8'h00);
      host.wr(AF, 8'h04);
      cyc(2);
      chk(b(alert_oe), 8'h01);
      // Thermal shutdown in both response modes, then recovery
      for (int m = 0; m < 2; m++) begin
         restart(ok, 75);
         host.wr(AS, m ? 8'h10 : 8'h00);
         c = ok;
         c.t_gt_125 = 1'h1;
         c.t_lt_100 = 1'h0;
         c.t_ge_150 = 1'h1;
         apply(c);
         chk(b(pwr.blk_on), 8'h00);
         pchk(m ? 1'h0 : 1'h1, m ? MO : MB);
         rchk(AF, 8'h03);
         chk(b(alert_oe), 8'h00);
         c.t_ge_150 = 1'h0;
         c.str_below_buckoff = 1'h1;
         apply(c);
         chk({6'h0, pwr.mode}, {6'h0, MO});
         host.wr(AF, 8'h01);
         rchk(AF, 8'h03);
         c.t_gt_125 = 1'h0;
         c.str_below_buckoff = 1'h0;
         apply(c);
         chk(b(pwr.blk_on), 8'h01);
         host.wr(AF, 8'h01);
         rchk(AF, 8'h02);
      end
      // Highest temperature turns everything off
      restart(ok, 75);
      c.t_gt_125 = 1'h1;
      c.t_ge_150 = 1'h1;
      c.t_ge_165 = 1'h1;
      apply(c);
      chk(b(pwr.blk_on), 8'h00);
      pchk(1'h0, MO);
      end_of_test();
   end
endmodule
`default_nettype wire
